// *** rtl/isp_line_filter.sv ***
// Three-stage synchroniser with optional debounce for one bus line
`timescale 1ns/1ps
module isp_line_filter import isp_pkg::*; #(
    parameter int CNT_W = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    input wire logic [1:0] sel,
    output logic level
);
    logic [2:0] sync_q, sync_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] need;
    logic level_d;

    if (CNT_W < 3) begin : g_chk
        $error("isp_line_filter: CNT_W too small for debounce");
    end

    always_comb begin
        sync_d = {sync_q[1:0], pin};
        if (sel == DEB_NONE) begin
            need = '0;
        end else if (sel == DEB_SHORT) begin
            need = CNT_W'(DEB_SHORT_CLKS);
        end else begin
            need = CNT_W'(DEB_LONG_CLKS);
        end
        level_d = level;
        cnt_d = '0;
        // Second and third stages must agree before a change counts
        if ((sync_q[1] == sync_q[2]) && (sync_q[2] != level)) begin
            if (cnt_q >= need) begin
                level_d = sync_q[2];
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync_q <= 3'b111;
            cnt_q <= '0;
            level <= 1'b1;
        end else begin
            sync_q <= sync_d;
            cnt_q <= cnt_d;
            level <= level_d;
        end
    end
endmodule

// *** rtl/isp_pkg.sv ***
// Register map, field layouts and state encoding of the I2C slave port
package isp_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_ADDR = 8'h0C;
    localparam logic [7:0] OFS_TOUT = 8'h10;

    localparam logic [7:0] CTRL_RST = 8'hE0;
    localparam logic [7:0] STAT_RST = 8'h81;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] TOUT_RST = 8'h00;

    localparam logic [2:0] MODE_I2C = 3'b110;
    localparam int ADDR_LSB = 1;
    localparam int TOUT_FLAG_BIT = 6;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [2:0] HSIZE_WORD = 3'b010;

    localparam logic [1:0] DEB_NONE = 2'b00;
    localparam logic [1:0] DEB_SHORT = 2'b01;
    localparam logic [2:0] DEB_SHORT_CLKS = 3'h2;
    localparam logic [2:0] DEB_LONG_CLKS = 3'h4;

    typedef struct packed {
        logic [2:0] interface_mode_sel;
        logic uart_select;
        logic [1:0] glitch_filter_sel;
        logic port_enable;
        logic spi_incomplete_flag;
    } isp_ctrl_t;

    typedef struct packed {
        logic byte_done_flag;
        logic addr_match_flag;
        logic bus_busy_flag;
        logic tx_select;
        logic ack_to_send;
        logic master_read_flag;
        logic match_wake_enable;
        logic ack_received_flag;
    } isp_status_t;

    typedef struct packed {
        logic tout_enable;
        logic timeout_flag;
        logic [5:0] tout_period;
    } isp_tout_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SHIFT = 3'b001,
        ST_ACK = 3'b011,
        ST_HOLD = 3'b010,
        ST_WAIT = 3'b110
    } isp_state_t;
endpackage

// *** rtl/isp_slave_port.sv ***
// I2C slave port with AHB-Lite register access
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// - Port runs only when enabled in I2C mode; otherwise pins released.
// - Enable rising restores status flags, keeps tx select and ack bit.
// - Byte-done low while shifting, set with interrupt after each data byte.
// - Address-match flag set on equal address, stays low otherwise.
// - Bus-busy set on START, cleared on STOP, regardless of address.
// - Transmit-select one makes the slave transmit, zero receive.
// - After eight received bits the ack bit is driven on clock nine.
// - Eighth bit after START is captured as master-read flag.
// - Address match raises a wake request when wake enable is set.
// - While transmitting, SDA on clock nine lands in ack-received flag.
// - Transmitter stops and releases SDA once master does not ack.
// - First seven bits after START are the address, MSB first.
// - On address match SDA is pulled low as ninth bit.
// - One interrupt; address-match and byte-done flags tell the cause.
// - SCL held low until data write or dummy read by software.
// - START is SDA falling with SCL high, only detected here.
// - Own address lives in bits 7 to 1 of the address register.
// - Data bytes are eight bits, MSB first.
// - SCL is debounced by none, two or four system clocks.
module isp_slave_port import isp_pkg::*; (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SCL_O,
    output logic SCL_OE,
    output logic SDA_O,
    output logic SDA_OE,
    output logic PORT_ACTIVE,
    output logic SERIAL_IRQ,
    output logic WAKE_REQ
);
    isp_ctrl_t ctrl_q, ctrl_d;
    isp_status_t stat_q, stat_d;
    isp_tout_t tout_q, tout_d;
    logic [7:0] data_q, data_d, own_q, own_d, shreg_q, shreg_d;
    isp_state_t st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic is_addr_q, is_addr_d, act_d, irq_d, wake_d;
    logic sda_oe_d, scl_oe_d, wr_q, wr_d;
    logic [7:0] wa_q;
    logic [31:0] hrdata_d;
    logic scl_lvl, sda_lvl, scl_prev_q, sda_prev_q;
    logic acc, rd_svc, wr_svc;
    logic start_evt, stop_evt, scl_rise, scl_fall;

    isp_line_filter #(.CNT_W(3)) u_scl (
        .clk(SYS_CLK),
        .rst(RST),
        .pin(SCL_I),
        .sel(ctrl_q.glitch_filter_sel),
        .level(scl_lvl)
    );

    isp_line_filter #(.CNT_W(3)) u_sda (
        .clk(SYS_CLK),
        .rst(RST),
        .pin(SDA_I),
        .sel(DEB_NONE),
        .level(sda_lvl)
    );

    assign acc = HSEL & HTRANS[1] & HREADY & (HSIZE == HSIZE_WORD);
    assign rd_svc = acc & ~HWRITE & (HADDR == OFS_DATA);
    assign wr_svc = wr_q & (wa_q == OFS_DATA);
    assign start_evt = scl_lvl & sda_prev_q & ~sda_lvl;
    assign stop_evt = scl_lvl & ~sda_prev_q & sda_lvl;
    assign scl_rise = scl_lvl & ~scl_prev_q;
    assign scl_fall = ~scl_lvl & scl_prev_q;

    always_comb begin
        ctrl_d = ctrl_q;
        stat_d = stat_q;
        tout_d = tout_q;
        data_d = data_q;
        own_d = own_q;
        st_d = st_q;
        bit_d = bit_q;
        shreg_d = shreg_q;
        is_addr_d = is_addr_q;
        sda_oe_d = SDA_OE;
        scl_oe_d = SCL_OE;
        irq_d = 1'b0;
        wake_d = 1'b0;
        wr_d = acc & HWRITE;
        hrdata_d = 32'h0000_0000;
        // Register writes land in the data phase
        if (wr_q) begin
            case (wa_q)
                OFS_CTRL: ctrl_d = isp_ctrl_t'(HWDATA[7:0]);
                OFS_STAT: begin
                    stat_d.tx_select = HWDATA[4];
                    stat_d.ack_to_send = HWDATA[3];
                    stat_d.match_wake_enable = HWDATA[1];
                end
                OFS_DATA: data_d = HWDATA[7:0];
                OFS_ADDR: own_d = HWDATA[7:0];
                OFS_TOUT: begin
                    tout_d.tout_enable = HWDATA[7];
                    tout_d.tout_period = HWDATA[5:0];
                    if (!HWDATA[TOUT_FLAG_BIT]) begin
                        tout_d.timeout_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        act_d = ctrl_d.port_enable & ~ctrl_d.uart_select &
            (ctrl_d.interface_mode_sel == MODE_I2C);
        if (!PORT_ACTIVE) begin
            st_d = ST_IDLE;
            sda_oe_d = 1'b0;
            scl_oe_d = 1'b0;
        end else if (start_evt) begin
            stat_d.bus_busy_flag = 1'b1;
            stat_d.addr_match_flag = 1'b0;
            stat_d.byte_done_flag = 1'b0;
            st_d = ST_SHIFT;
            bit_d = 4'h0;
            is_addr_d = 1'b1;
            sda_oe_d = 1'b0;
            scl_oe_d = 1'b0;
        end else if (stop_evt) begin
            stat_d.bus_busy_flag = 1'b0;
            st_d = ST_IDLE;
            sda_oe_d = 1'b0;
            scl_oe_d = 1'b0;
        end else begin
            case (st_q)
                ST_SHIFT: begin
                    if (scl_rise) begin
                        shreg_d = {shreg_q[6:0], sda_lvl};
                        bit_d = bit_q + 4'h1;
                    end
                    if (scl_fall && bit_q == BITS_PER_BYTE) begin
                        st_d = ST_ACK;
                        if (is_addr_q) begin
                            if (shreg_q[7:1] == own_q[7:ADDR_LSB]) begin
                                stat_d.addr_match_flag = 1'b1;
                                stat_d.master_read_flag = shreg_q[0];
                                sda_oe_d = 1'b1;
                                irq_d = 1'b1;
                                wake_d = stat_q.match_wake_enable;
                            end else begin
                                st_d = ST_WAIT;
                                sda_oe_d = 1'b0;
                            end
                        end else if (stat_q.tx_select) begin
                            sda_oe_d = 1'b0;
                        end else begin
                            data_d = shreg_q;
                            sda_oe_d = ~stat_q.ack_to_send;
                        end
                    end else if (scl_fall && stat_q.tx_select &&
                                 !is_addr_q) begin
                        sda_oe_d = ~data_q[~bit_q[2:0]];
                    end
                end
                ST_ACK: begin
                    if (scl_rise && !is_addr_q && stat_q.tx_select) begin
                        stat_d.ack_received_flag = sda_lvl;
                    end
                    if (scl_fall) begin
                        sda_oe_d = 1'b0;
                        if (!is_addr_q) begin
                            stat_d.byte_done_flag = 1'b1;
                            irq_d = 1'b1;
                        end
                        if (!is_addr_q && stat_q.tx_select &&
                            stat_q.ack_received_flag) begin
                            st_d = ST_WAIT;
                        end else begin
                            st_d = ST_HOLD;
                            scl_oe_d = 1'b1;
                        end
                    end
                end
                ST_HOLD: begin
                    if (wr_svc || rd_svc) begin
                        scl_oe_d = 1'b0;
                        st_d = ST_SHIFT;
                        bit_d = 4'h0;
                        is_addr_d = 1'b0;
                        stat_d.byte_done_flag = 1'b0;
                        sda_oe_d = stat_d.tx_select & ~data_d[7];
                    end
                end
                ST_WAIT: begin
                    sda_oe_d = 1'b0;
                    scl_oe_d = 1'b0;
                end
                ST_IDLE: ;
                default: st_d = ST_IDLE;
            endcase
        end
        if (act_d && !PORT_ACTIVE) begin
            stat_d.byte_done_flag = 1'b1;
            stat_d.addr_match_flag = 1'b0;
            stat_d.bus_busy_flag = 1'b0;
            stat_d.master_read_flag = 1'b0;
            stat_d.ack_received_flag = 1'b1;
        end
        // Read data taken from next values so a preceding write is seen
        if (acc && !HWRITE) begin
            case (HADDR)
                OFS_CTRL: hrdata_d = {24'h000000, ctrl_d};
                OFS_STAT: hrdata_d = {24'h000000, stat_d};
                OFS_DATA: hrdata_d = {24'h000000, data_d};
                OFS_ADDR: hrdata_d = {24'h000000, own_d};
                OFS_TOUT: hrdata_d = {24'h000000, tout_d};
                default: hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ctrl_q <= isp_ctrl_t'(CTRL_RST);
            stat_q <= isp_status_t'(STAT_RST);
            tout_q <= isp_tout_t'(TOUT_RST);
            data_q <= DATA_RST;
            own_q <= ADDR_RST;
            shreg_q <= 8'h00;
            st_q <= ST_IDLE;
            bit_q <= 4'h0;
            is_addr_q <= 1'b0;
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            HRDATA <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            SCL_O <= 1'b0;
            SDA_O <= 1'b0;
            SCL_OE <= 1'b0;
            SDA_OE <= 1'b0;
            PORT_ACTIVE <= 1'b0;
            SERIAL_IRQ <= 1'b0;
            WAKE_REQ <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            tout_q <= tout_d;
            data_q <= data_d;
            own_q <= own_d;
            shreg_q <= shreg_d;
            st_q <= st_d;
            bit_q <= bit_d;
            is_addr_q <= is_addr_d;
            wr_q <= wr_d;
            wa_q <= HADDR;
            scl_prev_q <= scl_lvl;
            sda_prev_q <= sda_lvl;
            HRDATA <= hrdata_d;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            SCL_O <= 1'b0;
            SDA_O <= 1'b0;
            SCL_OE <= scl_oe_d;
            SDA_OE <= sda_oe_d;
            PORT_ACTIVE <= act_d;
            SERIAL_IRQ <= irq_d;
            WAKE_REQ <= wake_d;
        end
    end

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    chk_busy_start: assert property (
        PORT_ACTIVE && start_evt |=> stat_q.bus_busy_flag)
        else $error("bus busy not set after start");
    chk_busy_stop: assert property (
        PORT_ACTIVE && stop_evt && !start_evt |=> !stat_q.bus_busy_flag)
        else $error("bus busy not cleared after stop");
    chk_pins_off: assert property (
        !PORT_ACTIVE |=> !SDA_OE && !SCL_OE)
        else $error("pins driven while port disabled");
    chk_enable_flags: assert property (
        $rose(PORT_ACTIVE) |-> stat_q.byte_done_flag &&
        !stat_q.addr_match_flag && stat_q.ack_received_flag)
        else $error("flags not restored on enable");
    chk_match_ack: assert property (
        $rose(stat_q.addr_match_flag) |-> SDA_OE && SERIAL_IRQ)
        else $error("address match without ack and interrupt");
    chk_byte_irq: assert property (
        $rose(stat_q.byte_done_flag) && PORT_ACTIVE &&
        $past(PORT_ACTIVE) |-> SERIAL_IRQ)
        else $error("byte done without interrupt");
    chk_hold_scl: assert property (
        st_q == ST_HOLD && !(wr_svc || rd_svc) && !start_evt &&
        !stop_evt && PORT_ACTIVE |=> SCL_OE)
        else $error("clock released without service");
    chk_nack_release: assert property (
        st_q == ST_WAIT |-> !SDA_OE && !SCL_OE)
        else $error("line held after no acknowledge");
    chk_wake_gate: assert property (
        WAKE_REQ |-> $past(stat_q.match_wake_enable) &&
        stat_q.addr_match_flag)
        else $error("wake without enable or match");

    cov_start: cover property (PORT_ACTIVE && start_evt);
    cov_match: cover property ($rose(stat_q.addr_match_flag));
    cov_byte: cover property ($rose(stat_q.byte_done_flag));
    cov_release: cover property (st_q == ST_HOLD ##1 st_q == ST_SHIFT);
endmodule

// *** tb/i2c_slave_port_bench.sv ***
// Self-checking bench for the I2C slave port against a bus master model
`timescale 1ns/1ps
module i2c_slave_port_bench import isp_pkg::*;;
    localparam int TIMEOUT = 20000;
    logic sys_clk;
    logic rst;
    logic hsel;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
    logic port_active;
    logic serial_irq;
    logic wake_req;
    logic m_scl_low;
    logic m_sda_low;
    logic [7:0] rd;
    logic ack;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int irq_n = 0;
    int wake_n = 0;
    logic [7:0] rst_tab [6] = '{8'hE0, 8'h81, 8'h00, 8'h00, 8'h00, 8'h00};
    wire scl_line = !(m_scl_low || (scl_oe && !scl_o));
    wire sda_line = !(m_sda_low || (sda_oe && !sda_o));

    isp_slave_port uut (
        .SYS_CLK(sys_clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .SCL_I(scl_line),
        .SDA_I(sda_line), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_O(sda_o),
        .SDA_OE(sda_oe), .PORT_ACTIVE(port_active),
        .SERIAL_IRQ(serial_irq), .WAKE_REQ(wake_req)
    );

    isp_i2c_master far_master (
        .scl(scl_line), .sda(sda_line),
        .scl_low(m_scl_low), .sda_low(m_sda_low)
    );

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic test_done();
        $display("Checks %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (serial_irq === 1'b1) irq_n <= irq_n + 1;
        if (wake_req === 1'b1) wake_n <= wake_n + 1;
        if (cycles == TIMEOUT) begin
            errors++;
            test_done();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic bus_op(input logic w, input logic [7:0] a,
            input logic [7:0] wd, output logic [7:0] rdat);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        hsize <= HSIZE_WORD;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h000000, wd};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rdat = hrdata[7:0];
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus_op(1'b1, a, d, x);
    endtask

    task automatic chk8(input string what, input logic [7:0] seen,
            input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk1(input string what, input logic seen,
            input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic chk_reg(input string what, input logic [7:0] a,
            input logic [7:0] mask, input logic [7:0] exp);
        bus_op(1'b0, a, 8'h00, rd);
        chk8(what, rd & mask, exp);
    endtask

    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h00000000;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            chk_reg("reset", 8'(i * 4), 8'hFF, rst_tab[i]);
        end
        wr(8'h14, 8'hFF);
        chk_reg("unmapped", 8'h14, 8'hFF, 8'h00);
        wr(OFS_TOUT, 8'hFF);
        chk_reg("tout", OFS_TOUT, 8'hFF, 8'hBF);
        wr(OFS_ADDR, 8'hB5);
        far_master.start_cond();
        far_master.write_byte(8'hB4, ack);
        chk1("ack while off", ack, 1'b1);
        far_master.stop_cond();
        chk_reg("stat off", OFS_STAT, 8'hFF, 8'h81);
        wr(OFS_CTRL, 8'hC2);
        chk1("okay resp", hresp, 1'b0);
        tick(2);
        chk1("port on", port_active, 1'b1);
        far_master.start_cond();
        tick(10);
        chk_reg("busy", OFS_STAT, 8'h20, 8'h20);
        far_master.write_byte(8'hB4, ack);
        chk1("addr ack", ack, 1'b0);
        tick(12);
        chk1("stretch", scl_oe, 1'b1);
        chk_reg("match", OFS_STAT, 8'h64, 8'h60);
        chk1("irq", irq_n != 0, 1'b1);
        chk1("no wake", wake_n == 0, 1'b1);
        wr(OFS_STAT, 8'h00);
        bus_op(1'b0, OFS_DATA, 8'h00, rd);
        tick(3);
        chk1("released", scl_oe, 1'b0);
        far_master.write_byte(8'hA5, ack);
        chk1("data ack", ack, 1'b0);
        tick(12);
        chk_reg("done", OFS_STAT, 8'h80, 8'h80);
        chk1("stretch", scl_oe, 1'b1);
        wr(OFS_STAT, 8'h08);
        chk_reg("data", OFS_DATA, 8'hFF, 8'hA5);
        fork
            far_master.write_byte(8'h3C, ack);
            begin
                tick(40);
                chk_reg("moving", OFS_STAT, 8'h80, 8'h00);
            end
        join
        chk1("nack sent", ack, 1'b1);
        tick(12);
        chk_reg("data", OFS_DATA, 8'hFF, 8'h3C);
        far_master.stop_cond();
        tick(10);
        chk_reg("stop", OFS_STAT, 8'h20, 8'h00);
        chk1("lines free", sda_oe | scl_oe, 1'b0);
        chk1("pin level", sda_o | scl_o, 1'b0);
        far_master.start_cond();
        far_master.write_byte(8'h22, ack);
        chk1("foreign ack", ack, 1'b1);
        tick(12);
        chk_reg("foreign", OFS_STAT, 8'h60, 8'h20);
        far_master.stop_cond();
        wr(OFS_STAT, 8'h02);
        far_master.start_cond();
        far_master.write_byte(8'hB5, ack);
        chk1("read ack", ack, 1'b0);
        tick(12);
        chk_reg("read req", OFS_STAT, 8'h64, 8'h64);
        chk1("wake", wake_n == 1, 1'b1);
        wr(OFS_STAT, 8'h10);
        wr(OFS_DATA, 8'hC3);
        far_master.read_byte(1'b0, rd);
        chk8("tx byte", rd, 8'hC3);
        tick(12);
        chk_reg("rx ack", OFS_STAT, 8'h01, 8'h00);
        wr(OFS_DATA, 8'h96);
        far_master.read_byte(1'b1, rd);
        chk8("tx byte", rd, 8'h96);
        tick(12);
        chk_reg("rx nack", OFS_STAT, 8'h01, 8'h01);
        chk1("tx released", sda_oe | scl_oe, 1'b0);
        far_master.stop_cond();
        wr(OFS_CTRL, 8'hC0);
        tick(2);
        chk1("port off", port_active, 1'b0);
        wr(OFS_CTRL, 8'hC2);
        chk_reg("enable", OFS_STAT, 8'hFF, 8'h91);
        test_done();
    end
endmodule

// *** tb/isp_i2c_master.sv ***
// Behavioural I2C bus master model with open-drain line drivers
`timescale 1ns/1ps
module isp_i2c_master #(
    parameter int LOW_NS = 220,
    parameter int HIGH_NS = 100
) (
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // Data moves only while SCL is low; slave stretch is honoured
    task automatic clk_bit(input logic send, output logic got);
        #(LOW_NS / 3) sda_low = ~send;
        #(LOW_NS * 2 / 3) scl_low = 1'b0;
        wait (scl === 1'b1);
        #(HIGH_NS / 2) got = sda;
        #(HIGH_NS / 2) scl_low = 1'b1;
    endtask

    task automatic start_cond();
        #(HIGH_NS) sda_low = 1'b1;
        #(HIGH_NS) scl_low = 1'b1;
    endtask

    task automatic stop_cond();
        #(LOW_NS / 3) sda_low = 1'b1;
        #(LOW_NS * 2 / 3) scl_low = 1'b0;
        wait (scl === 1'b1);
        #(HIGH_NS) sda_low = 1'b0;
        #(HIGH_NS);
    endtask

    // Ninth bit leaves SDA free and samples the slave's answer
    task automatic write_byte(input logic [7:0] b, output logic nack);
        logic d;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(b[i], d);
        end
        clk_bit(1'b1, nack);
    endtask

    task automatic read_byte(input logic nack, output logic [7:0] b);
        logic d;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, b[i]);
        end
        clk_bit(nack, d);
    endtask
endmodule
